// ---- hw/alarm_monitor_defs.vh ----
// constants for the dual alarm monitor: register offsets, fields, resets
// assumes byte addressing on a 32-bit avalon-mm slave, one register per word
`ifndef ALARM_MONITOR_DEFS_VH
`define ALARM_MONITOR_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_ALARM_CONTROL      6'h00
`define OFS_ALARM_THRESHOLD_1  6'h04
`define OFS_ALARM_THRESHOLD_2  6'h08
`define OFS_ALARM_SAMPLE_CNT_1 6'h0C
`define OFS_ALARM_SAMPLE_CNT_2 6'h10
`define OFS_SAMPLE_PERIOD      6'h14
`define OFS_DIAG_STATUS        6'h18
`define OFS_IRQ_STATUS         6'h1C
`define OFS_IRQ_MASK           6'h20

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_ALARM_CONTROL      16'h0000
`define RST_ALARM_THRESHOLD    16'h0000
`define RST_ALARM_SAMPLE_CNT   16'h0000
`define RST_SAMPLE_PERIOD      16'h0001

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTL_SRC2_HI    15
`define CTL_SRC2_LO    12
`define CTL_SRC1_HI    11
`define CTL_SRC1_LO    8
`define CTL_ROC2       7
`define CTL_ROC1       6
`define CTL_FILTER     4
`define CTL_OUT_EN     2
`define CTL_OUT_POL    1
`define CTL_OUT_SEL    0

// ----------------------------------------
// threshold and status fields
// ----------------------------------------
`define THR_DIR        15
`define THR_VAL_HI     13
`define DIAG_ALARM1    8
`define DIAG_ALARM2    9

// ----------------------------------------
// source codes
// ----------------------------------------
`define SRC_DISABLE    4'h0
`define SRC_LAST       4'hB
`define SRC_COUNT      12

`endif

// ---- hw/dual_alarm_monitor.v ----
// dual alarm monitor: two threshold / rate-of-change alarms on sensor data
// assumes sensor words arrive on one flat bus and sample_strobe marks each
// new sample set; registers reached over avalon-mm with waitrequest
//
// Summary of operation
// - two alarm channels run independently with their own source, threshold, sample-count and rate-mode settings.
// - a 4-bit source code picks disable, supply, gyro, accel, temps or aux input.
// - alarm 2 source is control bits 15:12 and alarm 1 source bits 11:8.
// - threshold bit 15 set fires above the threshold, clear fires below it.
// - threshold bits 13:0 hold the trigger value in the source format, bit 14 unused.
// - sample-count bits 7:0 give the rate window, 0 and 1 both meaning one sample.
// - the rate window is the sample count times the configured sample period.
// - control bit 7 puts alarm 2 and bit 6 alarm 1 into rate-of-change mode.
// - control bit 4 chooses filtered data, applied before the comparison.
// - control bits 2,1,0 enable the indicator, set its polarity and pick its line.
// - diagnostic status bit 9 shows alarm 2 and bit 8 alarm 1 active.
// - reading diagnostic status clears its flags, which set again next sample.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "alarm_monitor_defs.vh"

module dual_alarm_monitor #(
    parameter DATA_W = 14,
    parameter CNT_W  = 8
) (
    // clock and reset
    input  wire                        ref_clk,
    input  wire                        rst_n,
    // avalon-mm slave
    input  wire [5:0]                  avs_address,
    input  wire                        avs_read,
    input  wire                        avs_write,
    input  wire [31:0]                 avs_writedata,
    input  wire [3:0]                  avs_byteenable,
    output reg  [31:0]                 avs_readdata,
    output wire                        avs_waitrequest,
    // sensor data, 12 words of DATA_W, source code n at slot n-1
    input  wire                        sample_strobe,
    input  wire [DATA_W*`SRC_COUNT-1:0] raw_data,
    input  wire [DATA_W*`SRC_COUNT-1:0] filtered_data,
    // indicator lines and interrupt
    output reg                         first_io_line,
    output reg                         first_io_line_oe,
    output reg                         second_io_line,
    output reg                         second_io_line_oe,
    output wire                        irq
);

// ----------------------------------------
// registers
// ----------------------------------------
reg  [15:0]      alarm_control;
reg  [15:0]      alarm_threshold_1;
reg  [15:0]      alarm_threshold_2;
reg  [15:0]      alarm_sample_count_1;
reg  [15:0]      alarm_sample_count_2;
reg  [15:0]      sample_period_setting;
reg  [15:0]      diagnostic_status_word;
reg  [1:0]       irq_status;
reg  [1:0]       irq_mask;
reg              ack;
reg  [15:0]      period_cnt;
wire             period_tick;
wire [1:0]       alarm_now;

// ----------------------------------------
// bus handshake
// ----------------------------------------
// single wait state: request taken on the second edge it is held
assign avs_waitrequest = (avs_read | avs_write) & ~ack;
wire   acc_rd = avs_read & ack;
wire   acc_wr = avs_write & ack;
wire   lo_ok  = avs_byteenable[0];
wire   hi_ok  = avs_byteenable[1];

// ----------------------------------------
// sample period divider
// ----------------------------------------
// one observation tick every sample_period_setting strobes, zero read as one
assign period_tick = sample_strobe &
                     (period_cnt + 16'h0001 >= sample_period_setting);
// a lowered setting takes hold at the next strobe, no wrap needed

always @(posedge ref_clk) begin
    if (!rst_n) begin
        period_cnt <= 16'h0000;
    end else if (period_tick) begin
        period_cnt <= 16'h0000;
    end else if (sample_strobe) begin
        period_cnt <= period_cnt + 16'h0001;
    end
end

// ----------------------------------------
// alarm channels
// ----------------------------------------
// one generate body per channel keeps the two alarms identical
genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
        wire [15:0]       thr   = (ch == 0) ? alarm_threshold_1 : alarm_threshold_2;
        wire [15:0]       scnt  = (ch == 0) ? alarm_sample_count_1 : alarm_sample_count_2;
        wire [3:0]        src   = (ch == 0) ? alarm_control[`CTL_SRC1_HI:`CTL_SRC1_LO]
                                            : alarm_control[`CTL_SRC2_HI:`CTL_SRC2_LO];
        wire              rate_of_change   = (ch == 0) ? alarm_control[`CTL_ROC1]
                                            : alarm_control[`CTL_ROC2];
        wire              valid = (src != `SRC_DISABLE) && (src <= `SRC_LAST);
        // codes 0 and past the aux input are gated by valid, so an off-bus slot read is never used
        wire [3:0]        slot  = src - 4'h1;
        wire [DATA_W-1:0] raw_w = raw_data[slot*DATA_W +: DATA_W];
        wire [DATA_W-1:0] flt_w = filtered_data[slot*DATA_W +: DATA_W];
        wire [DATA_W-1:0] cur   = alarm_control[`CTL_FILTER] ? flt_w : raw_w;
        wire [CNT_W-1:0]  nsm   = (scnt[CNT_W-1:0] == {CNT_W{1'b0}}) ?
                                  {{(CNT_W-1){1'b0}}, 1'b1} : scnt[CNT_W-1:0];
        // bit 14 ignored, sign taken from the top value bit
        wire signed [DATA_W:0]   thr_s = {thr[`THR_VAL_HI], thr[`THR_VAL_HI:0]};
        reg  [DATA_W-1:0] ref_val;
        reg  [CNT_W-1:0]  win_cnt;
        reg               primed;
        reg               active;
        wire signed [DATA_W:0]   diff  = $signed({cur[DATA_W-1], cur}) -
                                         $signed({ref_val[DATA_W-1], ref_val});
        wire signed [DATA_W:0]   mon   = rate_of_change ? diff : $signed({cur[DATA_W-1], cur});
        wire              hit   = thr[`THR_DIR] ? (mon > thr_s) : (mon < thr_s);
        wire              win_end = period_tick && (win_cnt + 1'b1 >= nsm);

        // ----------------------------------------
        // channel state
        // ----------------------------------------
        always @(posedge ref_clk) begin
            if (!rst_n) begin
                ref_val <= {DATA_W{1'b0}};
                win_cnt <= {CNT_W{1'b0}};
                primed  <= 1'b0;
                active  <= 1'b0;
            end else if (!valid) begin
                win_cnt <= {CNT_W{1'b0}};
                primed  <= 1'b0;
                active  <= 1'b0;
            end else if (!rate_of_change) begin
                primed  <= 1'b0;
                win_cnt <= {CNT_W{1'b0}};
                if (sample_strobe) begin
                    active <= hit;
                end
            end else if (win_end) begin
                // rate compare once per window, then re-arm the reference
                win_cnt <= {CNT_W{1'b0}};
                ref_val <= cur;
                primed  <= 1'b1;
                active  <= primed & hit;
            end else if (period_tick) begin
                win_cnt <= win_cnt + 1'b1;
                if (!primed) begin
                    ref_val <= cur;
                    primed  <= 1'b1;
                    win_cnt <= {CNT_W{1'b0}};
                end
            end
        end
        assign alarm_now[ch] = active;
    end
endgenerate

// ----------------------------------------
// indicator output
// ----------------------------------------
wire any_alarm = |alarm_now;
wire ind_level = any_alarm ^ ~alarm_control[`CTL_OUT_POL];
// lines follow the level while undriven, so enabling shows no stale value

always @(posedge ref_clk) begin
    if (!rst_n) begin
        first_io_line     <= 1'b0;
        first_io_line_oe  <= 1'b0;
        second_io_line    <= 1'b0;
        second_io_line_oe <= 1'b0;
    end else begin
        first_io_line     <= ind_level;
        second_io_line    <= ind_level;
        first_io_line_oe  <= alarm_control[`CTL_OUT_EN] & ~alarm_control[`CTL_OUT_SEL];
        second_io_line_oe <= alarm_control[`CTL_OUT_EN] & alarm_control[`CTL_OUT_SEL];
    end
end

// ----------------------------------------
// register writes and sticky status
// ----------------------------------------
wire diag_rd = acc_rd && (avs_address == `OFS_DIAG_STATUS);
// only the low lane carries the two clear bits
wire [1:0] irq_clr = (acc_wr && (avs_address == `OFS_IRQ_STATUS) && lo_ok) ?
                     avs_writedata[1:0] : 2'b00;
// a new alarm edge beats a software clear in the same cycle
reg  [1:0] alarm_last;
wire [1:0] alarm_rise = alarm_now & ~alarm_last;

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge ref_clk) begin
    if (!rst_n) begin
        alarm_control          <= `RST_ALARM_CONTROL;
        alarm_threshold_1      <= `RST_ALARM_THRESHOLD;
        alarm_threshold_2      <= `RST_ALARM_THRESHOLD;
        alarm_sample_count_1   <= `RST_ALARM_SAMPLE_CNT;
        alarm_sample_count_2   <= `RST_ALARM_SAMPLE_CNT;
        sample_period_setting  <= `RST_SAMPLE_PERIOD;
        diagnostic_status_word <= 16'h0000;
        irq_status             <= 2'b00;
        irq_mask               <= 2'b00;
        alarm_last             <= 2'b00;
    end else begin
        alarm_last <= alarm_now;
        irq_status <= (irq_status & ~irq_clr) | alarm_rise;
        // read clears the flags; live alarms set them back on the next sample
        if (diag_rd) begin
            diagnostic_status_word <= 16'h0000;
        end else if (sample_strobe) begin
            diagnostic_status_word[`DIAG_ALARM1] <=
                diagnostic_status_word[`DIAG_ALARM1] | alarm_now[0];
            diagnostic_status_word[`DIAG_ALARM2] <=
                diagnostic_status_word[`DIAG_ALARM2] | alarm_now[1];
        end
        if (acc_wr) begin
            case (avs_address)
                `OFS_ALARM_CONTROL: begin
                    if (lo_ok) alarm_control[7:0] <= avs_writedata[7:0];
                    if (hi_ok) alarm_control[15:8] <= avs_writedata[15:8];
                end
                `OFS_ALARM_THRESHOLD_1: begin
                    if (lo_ok) alarm_threshold_1[7:0] <= avs_writedata[7:0];
                    if (hi_ok) alarm_threshold_1[15:8] <= avs_writedata[15:8] & 8'hBF;
                end
                `OFS_ALARM_THRESHOLD_2: begin
                    if (lo_ok) alarm_threshold_2[7:0] <= avs_writedata[7:0];
                    if (hi_ok) alarm_threshold_2[15:8] <= avs_writedata[15:8] & 8'hBF;
                end
                // count registers keep their upper byte at zero
                `OFS_ALARM_SAMPLE_CNT_1: begin
                    if (lo_ok) alarm_sample_count_1[7:0] <= avs_writedata[7:0];
                end
                `OFS_ALARM_SAMPLE_CNT_2: begin
                    if (lo_ok) alarm_sample_count_2[7:0] <= avs_writedata[7:0];
                end
                `OFS_SAMPLE_PERIOD: begin
                    if (lo_ok) sample_period_setting[7:0] <= avs_writedata[7:0];
                    if (hi_ok) sample_period_setting[15:8] <= avs_writedata[15:8];
                end
                `OFS_IRQ_MASK: begin
                    if (lo_ok) irq_mask <= avs_writedata[1:0];
                end
                default: begin
                end
            endcase
        end
    end
end

// ----------------------------------------
// interrupt output
// ----------------------------------------
// level output straight from registers, no extra cycle of delay
assign irq = |(irq_status & irq_mask);

// ----------------------------------------
// bus answer
// ----------------------------------------
// unmapped offsets and unused bits read zero, except control bits 5 and 3, which read back as written
reg [15:0] next_rdata;

always @* begin
    case (avs_address)
        `OFS_ALARM_CONTROL:      next_rdata = alarm_control;
        `OFS_ALARM_THRESHOLD_1:  next_rdata = alarm_threshold_1;
        `OFS_ALARM_THRESHOLD_2:  next_rdata = alarm_threshold_2;
        `OFS_ALARM_SAMPLE_CNT_1: next_rdata = alarm_sample_count_1;
        `OFS_ALARM_SAMPLE_CNT_2: next_rdata = alarm_sample_count_2;
        `OFS_SAMPLE_PERIOD:      next_rdata = sample_period_setting;
        `OFS_DIAG_STATUS:        next_rdata = diagnostic_status_word;
        `OFS_IRQ_STATUS:         next_rdata = {14'h0000, irq_status};
        `OFS_IRQ_MASK:           next_rdata = {14'h0000, irq_mask};
        default:                 next_rdata = 16'h0000;
    endcase
end

// ----------------------------------------
// wait state and read capture
// ----------------------------------------
// data captured on the waiting edge, so it stands when waitrequest drops
always @(posedge ref_clk) begin
    if (!rst_n) begin
        ack          <= 1'b0;
        avs_readdata <= 32'h00000000;
    end else begin
        ack <= (avs_read | avs_write) & ~ack;
        if ((avs_read | avs_write) & ~ack) begin
            avs_readdata <= {16'h0000, next_rdata};
        end
    end
end

endmodule

// ---- testbench/alarm_host.sv ----
// host model: avalon-mm master for the alarm monitor registers
// assumes the bench calls xfer from one process just after a clock edge
`timescale 1ns/100ps
module alarm_host (
    // clock
    input  wire        ref_clk,
    // avalon-mm master side
    output reg  [5:0]  avs_address    = 6'h00,
    output reg         avs_read       = 1'b0,
    output reg         avs_write      = 1'b0,
    output reg  [31:0] avs_writedata  = 32'h0,
    output reg  [3:0]  avs_byteenable = 4'h3,
    input  wire [31:0] avs_readdata,
    input  wire        avs_waitrequest
);
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // idle cycle, so the next request is a fresh rise
        @(posedge ref_clk);
    endtask
endmodule

// ---- testbench/dual_alarm_monitor_asserts.sv ----
// port checker for the dual alarm monitor
// assumes byte addresses, one 16-bit register per word
`timescale 1ns/100ps
module dual_alarm_monitor_asserts (
    input logic        ref_clk,
    input logic        rst_n,
    input logic [5:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0]  avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic        first_io_line_oe,
    input logic        second_io_line_oe,
    input logic        irq
);
    logic [15:0] ctl, ctl_d, mask;
    wire req  = avs_read || avs_write;
    wire done = avs_write && !avs_waitrequest;
    wire rok  = avs_read && !avs_waitrequest;
    function automatic logic [15:0] wd(input logic [15:0] o);
        return {avs_byteenable[1] ? avs_writedata[15:8] : o[15:8],
                avs_byteenable[0] ? avs_writedata[7:0] : o[7:0]};
    endfunction
    // shadow of control and mask, taken from completed writes
    always @(posedge ref_clk) begin
        ctl_d <= rst_n ? ctl : 16'h0000;
        if (!rst_n) begin
            ctl  <= 16'h0000;
            mask <= 16'h0000;
        end else if (done && avs_address == 6'h00) begin
            ctl <= wd(ctl);
        end else if (done && avs_address == 6'h20) begin
            mask <= wd(mask);
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_one_wait: assert property ($rose(req) |-> s_one_wait)
        else $error("wait state count wrong");
    a_wait_idle: assert property (avs_waitrequest |-> req)
        else $error("waitrequest without request");
    a_cnt_width: assert property (rok && avs_address inside {6'h0C, 6'h10}
        |-> avs_readdata[31:8] == 24'h0) else $error("count bits above 7 set");
    a_thr_gap: assert property (rok && avs_address inside {6'h04, 6'h08}
        |-> !avs_readdata[14]) else $error("threshold bit 14 set");
    a_diag_gap: assert property (rok && avs_address == 6'h18
        |-> avs_readdata[15:10] == 6'h00 && avs_readdata[7:0] == 8'h00)
        else $error("diag bits outside the alarms set");
    a_oe_first: assert property (first_io_line_oe == (ctl_d[2] && !ctl_d[0]))
        else $error("first line enable wrong");
    a_oe_second: assert property (second_io_line_oe == (ctl_d[2] && ctl_d[0]))
        else $error("second line enable wrong");
    a_oe_single: assert property (!(first_io_line_oe && second_io_line_oe))
        else $error("both lines driven");
    a_irq_masked: assert property (irq |-> |mask[1:0])
        else $error("irq with all masked");
endmodule
bind dual_alarm_monitor dual_alarm_monitor_asserts u_chk (.ref_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .first_io_line_oe, .second_io_line_oe, .irq);

// ---- testbench/dual_alarm_monitor_test.sv ----
// self-checking bench for the dual alarm monitor
// assumes the host model drives the bus, the bench drives sensor data
`timescale 1ns/100ps
`include "alarm_monitor_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dual_alarm_monitor_test;
    logic         ref_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         sample_strobe = 1'b0;
    logic [167:0] raw_data = 168'h0;
    logic [167:0] filtered_data = 168'h0;
    logic [15:0]  q;
    logic [13:0]  v = 14'h00C8;
    wire  [5:0]   avs_address;
    wire  [31:0]  avs_writedata, avs_readdata;
    wire  [3:0]   avs_byteenable;
    wire          avs_read, avs_write, avs_waitrequest, irq;
    wire          first_io_line, first_io_line_oe, second_io_line, second_io_line_oe;
    int           error_cnt = 0, tests_run = 0, cyc = 0;
    // rows: control, threshold 1, threshold 2, raw, filtered, alarms
    logic [77:0]  rows [6] = '{
        {16'h5500, 16'h8064, 16'h0064, 14'h00C8, 14'h0000, 2'b01},
        {16'h5500, 16'h8064, 16'h0064, 14'h0032, 14'h0000, 2'b10},
        {16'h5510, 16'h8064, 16'h0064, 14'h00C8, 14'h0032, 2'b10},
        {16'h5500, 16'hBF9C, 16'h7F9C, 14'h3F38, 14'h0000, 2'b10},
        {16'h0500, 16'h8064, 16'h8000, 14'h00C8, 14'h0000, 2'b01},
        {16'h5500, 16'h8064, 16'h0064, 14'h0064, 14'h0000, 2'b00}};
    logic [15:0]  rate_of_change [4] = '{{8'h02, 7'h00, 1'b0}, {8'h00, 7'h14, 1'b0},
                              {8'h01, 7'h14, 1'b0}, {8'h02, 7'h14, 1'b1}};
    always #2.5 ref_clk = ~ref_clk;
    dual_alarm_monitor u_dual_alarm_monitor (.ref_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sample_strobe, .raw_data, .filtered_data, .first_io_line, .first_io_line_oe,
        .second_io_line, .second_io_line_oe, .irq);
    alarm_host u_alarm_host (.ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest);
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [31:0] t;
        u_alarm_host.xfer(1'b1, a, {16'h0000, d}, t);
    endtask
    task automatic rd(input logic [5:0] a);
        logic [31:0] t;
        u_alarm_host.xfer(1'b0, a, 32'h0, t);
        q = t[15:0];
    endtask
    task automatic strobe;
        sample_strobe <= 1'b1;
        @(posedge ref_clk);
        sample_strobe <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // first read drops flags left over from the previous setup
    task automatic run_case(input logic [15:0] c, t1, t2, input logic [1:0] e);
        wr(`OFS_ALARM_CONTROL, c);
        wr(`OFS_ALARM_THRESHOLD_1, t1);
        wr(`OFS_ALARM_THRESHOLD_2, t2);
        strobe();
        rd(`OFS_DIAG_STATUS);
        strobe();
        rd(`OFS_DIAG_STATUS);
        `CHK("diag alarms", e, q[9:8])
        $display("case %h done", c);
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            raw_data[56 +: 14] <= rows[i][29:16];
            filtered_data[56 +: 14] <= rows[i][15:2];
            run_case(rows[i][77:62], rows[i][61:46], rows[i][45:30], rows[i][1:0]);
        end
        for (int c = 0; c < 16; c++) begin
            raw_data <= (c > 0 && c < 12) ? 168'h0C8 << ((c - 1) * 14) : 168'h0;
            run_case({c[3:0], 12'h000}, 16'h0000, 16'h8064,
                     (c > 0 && c < 12) ? 2'b10 : 2'b00);
        end
        rd(`OFS_SAMPLE_PERIOD);
        `CHK("period reset", 16'h0001, q)
        wr(`OFS_ALARM_SAMPLE_CNT_1, 16'hFFFF);
        rd(`OFS_ALARM_SAMPLE_CNT_1);
        `CHK("count width", 16'h00FF, q)
        wr(6'h3C, 16'hFFFF);
        rd(6'h3C);
        `CHK("unmapped", 16'h0000, q)
        raw_data <= 168'h0C8 << 56;
        run_case(16'h5500, 16'h8064, 16'h0064, 2'b01);
        rd(`OFS_DIAG_STATUS);
        `CHK("diag cleared", 2'b00, q[9:8])
        strobe();
        rd(`OFS_DIAG_STATUS);
        `CHK("diag set again", 2'b01, q[9:8])
        wr(`OFS_ALARM_CONTROL, 16'h5507);
        repeat (2) @(posedge ref_clk);
        `CHK("line2", 3'b011, {first_io_line_oe, second_io_line_oe, second_io_line})
        wr(`OFS_ALARM_CONTROL, 16'h5504);
        repeat (2) @(posedge ref_clk);
        `CHK("line1", 3'b100, {first_io_line_oe, second_io_line_oe, first_io_line})
        wr(`OFS_ALARM_CONTROL, 16'h0000);
        strobe();
        wr(`OFS_IRQ_STATUS, 16'h0003);
        wr(`OFS_ALARM_CONTROL, 16'h0500);
        strobe();
        `CHK("irq masked", 1'b0, irq)
        rd(`OFS_IRQ_STATUS);
        `CHK("irq status", 16'h0001, q)
        wr(`OFS_IRQ_MASK, 16'h0001);
        `CHK("irq on", 1'b1, irq)
        wr(`OFS_IRQ_STATUS, 16'h0001);
        `CHK("irq off", 1'b0, irq)
        wr(`OFS_SAMPLE_PERIOD, 16'h0002);
        wr(`OFS_ALARM_THRESHOLD_1, 16'h8032);
        wr(`OFS_ALARM_THRESHOLD_2, 16'h8032);
        foreach (rate_of_change[i]) begin
            wr(`OFS_ALARM_SAMPLE_CNT_1, {8'h00, rate_of_change[i][15:8]});
            wr(`OFS_ALARM_SAMPLE_CNT_2, {8'h00, rate_of_change[i][15:8]});
            wr(`OFS_ALARM_CONTROL, 16'h55C4);
            for (int k = 0; k < 22; k++) begin
                if (k == 12) rd(`OFS_DIAG_STATUS);
                v = v + {7'h00, rate_of_change[i][7:1]};
                raw_data[56 +: 14] <= v;
                strobe();
            end
            rd(`OFS_DIAG_STATUS);
            `CHK("rate alarm", {2{rate_of_change[i][0]}}, q[9:8])
            $display("rate case %0d done", i);
        end
        // mid-run reset: outputs drop at the next clock edge, registers return to reset values
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK("reset outputs", 3'b000, {first_io_line_oe, second_io_line_oe, irq})
        rst_n <= 1'b1;
        rd(`OFS_ALARM_CONTROL);
        `CHK("reset control", 16'h0000, q)
        rd(`OFS_SAMPLE_PERIOD);
        `CHK("reset period", 16'h0001, q)
        strobe();
        rd(`OFS_DIAG_STATUS);
        `CHK("reset diag", 16'h0000, q)
        $display("reset test done");
        wrap_up();
    end
endmodule
